// ### hw/sil_pkg.sv
// Purpose: Constants for the front-panel status lamp controller
// Assumes: 125 MHz reference clock, classic Wishbone register access
// Notes:   Byte addresses of word registers
package sil_pkg;
   localparam int          CLK_HZ          = 125_000_000;
   // Timing figures in their own units
   localparam int          PAUSE_MS        = 1000;
   localparam int          FLASH_ON_MS     = 250;
   localparam int          FLASH_OFF_MS    = 250;
   localparam int          SUSP_HALF_MS    = 2000;
   localparam int          DEB_CYC         = 32'(CLK_HZ / 1000);
   // Cycle counts derived from the rate
   localparam int          PAUSE_CYC       = 32'(CLK_HZ / 1000 * PAUSE_MS);
   localparam int          FLASH_ON_CYC    = 32'(CLK_HZ / 1000 * FLASH_ON_MS);
   localparam int          FLASH_OFF_CYC   = 32'(CLK_HZ / 1000 * FLASH_OFF_MS);
   localparam int          SUSP_HALF_CYC   = 32'(CLK_HZ / 1000 * SUSP_HALF_MS);
   // Register byte addresses
   localparam logic [7:0]  ADR_CTRL        = 8'h00;
   localparam logic [7:0]  ADR_STAT        = 8'h04;
   localparam logic [7:0]  ADR_IRQ_STAT    = 8'h08;
   localparam logic [7:0]  ADR_IRQ_EN      = 8'h0C;
   localparam logic [7:0]  ADR_IRQ_CLR     = 8'h10;
   localparam logic [7:0]  ADR_FAULT       = 8'h14;
   // Control register fields
   localparam int          CTRL_LAMP_A     = 0;
   localparam int          CTRL_LAMP_USB   = 1;
   localparam int          CTRL_LAMP_C     = 2;
   localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
   // Fault codes
   localparam logic [7:0]  FC_NONE         = 8'h00;
   localparam logic [7:0]  FC_STBY_RAIL    = 8'h01;
   localparam logic [7:0]  FC_VIN          = 8'h02;
   localparam logic [7:0]  FC_EXT_PSU      = 8'h03;
   localparam logic [7:0]  FC_CPU_HOT      = 8'h04;
   localparam logic [7:0]  FC_LIVE_TMO     = 8'h05;
   localparam logic [7:0]  FC_SYSRST_TMO   = 8'h06;
   localparam logic [7:0]  FC_PLTRST       = 8'h07;
   localparam logic [7:0]  FC_HANDSHAKE    = 8'h08;
   localparam logic [7:0]  FC_PWROK        = 8'h09;
   localparam logic [7:0]  FC_INVALID      = 8'hFF;
   localparam int          N_FAULT_IN      = 9;
   // Interrupt status bits
   localparam int          IRQ_FAULT       = 0;
   localparam int          IRQ_LIVE        = 1;
   localparam int          IRQ_S0          = 2;
   localparam int          IRQ_S3          = 3;
   localparam int          IRQ_S5          = 4;
   localparam int          N_IRQ           = 5;
   // Host power states
   typedef enum logic [1:0] {
      SIL_PS_S0 = 2'b00,
      SIL_PS_S3 = 2'b01,
      SIL_PS_S5 = 2'b10,
      SIL_PS_BAD = 2'b11
   } sil_pstate_t;
endpackage : sil_pkg

// ### hw/sil_flasher.sv
// Purpose: Burst flasher, n flashes then a long pause, repeating
// Assumes: Code is stable while enable is high
// Notes:   Restarts from the first flash when enable rises
`timescale 1ns/1ps
`default_nettype none
module sil_flasher
   import sil_pkg::*;
#(
   parameter int ON_CYC    = FLASH_ON_CYC,
   parameter int OFF_CYC   = FLASH_OFF_CYC,
   parameter int PAUSE_C   = PAUSE_CYC
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Control
   input  wire logic       en_i,
   input  wire logic [7:0] code_i,
   // Lamp drive
   output logic            lamp_o
);
   typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF, FL_PAUSE} sil_fl_t;
   sil_fl_t     state_r;
   logic [31:0] cnt_r;
   logic [7:0]  left_r;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !en_i) begin
         state_r <= FL_IDLE;
         cnt_r   <= '0;
         left_r  <= '0;
         lamp_o  <= 1'b0;
      end else begin
         case (state_r)
            FL_IDLE: begin
               state_r <= FL_ON;
               left_r  <= code_i;
               cnt_r   <= '0;
               lamp_o  <= 1'b1;
            end
            FL_ON: begin
               if (cnt_r >= 32'(ON_CYC - 1)) begin
                  cnt_r   <= '0;
                  lamp_o  <= 1'b0;
                  left_r  <= left_r - 8'h01;
                  // Last flash of the burst leads to the pause
                  state_r <= (left_r == 8'h01) ? FL_PAUSE : FL_OFF;
               end else begin
                  cnt_r <= cnt_r + 32'h0000_0001;
               end
            end
            FL_OFF: begin
               if (cnt_r >= 32'(OFF_CYC - 1)) begin
                  cnt_r   <= '0;
                  lamp_o  <= 1'b1;
                  state_r <= FL_ON;
               end else begin
                  cnt_r <= cnt_r + 32'h0000_0001;
               end
            end
            FL_PAUSE: begin
               if (cnt_r >= 32'(PAUSE_C - 1)) begin
                  state_r <= FL_IDLE;
                  cnt_r   <= '0;
               end else begin
                  cnt_r <= cnt_r + 32'h0000_0001;
               end
            end
            default: begin
               state_r <= FL_IDLE;
               lamp_o  <= 1'b0;
            end
         endcase
      end
   end
endmodule : sil_flasher
`default_nettype wire

// ### hw/sil_lamp_ctrl.sv
// Purpose: Front-panel indicator lamp controller with Wishbone registers
// Assumes: Host and fault inputs are asynchronous pins
// Notes:   Fault code latches until restart or full power-off
`timescale 1ns/1ps
`default_nettype none
module sil_lamp_ctrl
   import sil_pkg::*;
#(
   parameter int PAUSE_C   = PAUSE_CYC,
   parameter int ON_CYC    = FLASH_ON_CYC,
   parameter int OFF_CYC   = FLASH_OFF_CYC,
   parameter int SUSP_CYC  = SUSP_HALF_CYC,
   parameter int N_ETH     = 2
) (
   // Clock and reset
   input  wire logic             REF_CLK_I,
   input  wire logic             RSTN_I,
   // Wishbone slave
   input  wire logic             WB_CYC_I,
   input  wire logic             WB_STB_I,
   input  wire logic             WB_WE_I,
   input  wire logic [7:0]       WB_ADR_I,
   input  wire logic [3:0]       WB_SEL_I,
   input  wire logic [31:0]      WB_DAT_I,
   output logic [31:0]           WB_DAT_O,
   output logic                  WB_ACK_O,
   // Host power and boot signals
   input  wire logic             HOST_S3_I,
   input  wire logic             HOST_S5_I,
   input  wire logic             LIVE_SIGN_I,
   input  wire logic             RAIL_12V_OK_I,
   // Fault inputs, bit k is code k+1
   input  wire logic [8:0]       FAULT_I,
   // Ethernet status
   input  wire logic [N_ETH-1:0] ETH_LINK_I,
   input  wire logic [N_ETH-1:0] ETH_ACT_I,
   // Lamps and interrupt
   output logic                  POWER_GOOD_LAMP_O,
   output logic                  SYSTEM_STATUS_LAMP_O,
   output logic                  GENERAL_LAMP_FIRST_O,
   output logic                  USB_ACTIVITY_LAMP_O,
   output logic                  GENERAL_LAMP_SECOND_O,
   output logic [N_ETH-1:0]      ETH_LINK_LAMP_O,
   output logic [N_ETH-1:0]      ETH_ACT_LAMP_O,
   output logic                  IRQ_O
);
   localparam int NS = 4 + N_FAULT_IN + 2 * N_ETH;
   // Two-flop synchronisers for every pin input
   logic [NS-1:0]   sy1_r;
   logic [NS-1:0]   sy2_r;
   logic            s3_s, s5_s, live_s, rail_s;
   logic [8:0]      flt_s;
   logic [N_ETH-1:0] lnk_s, act_s;
   // Reset reads as soft-off, so no false state event follows reset
   localparam logic [NS-1:0] SY_RST = {{(NS - 2){1'b0}}, 2'b10};

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         sy1_r <= SY_RST;
         sy2_r <= SY_RST;
      end else begin
         sy1_r <= {ETH_ACT_I, ETH_LINK_I, FAULT_I,
                   RAIL_12V_OK_I, LIVE_SIGN_I, HOST_S5_I, HOST_S3_I};
         sy2_r <= sy1_r;
      end
   end
   assign {act_s, lnk_s, flt_s, rail_s, live_s, s5_s, s3_s} = sy2_r;

   // Power state decode
   sil_pstate_t pstate;
   always_comb begin
      case ({s5_s, s3_s})
         2'b00:   pstate = SIL_PS_S0;
         2'b01:   pstate = SIL_PS_S3;
         2'b10:   pstate = SIL_PS_S5;
         default: pstate = SIL_PS_BAD;
      endcase
   end

   // Live sign seen since power-up, cleared whenever the host leaves S0
   logic live_seen_r;
   logic live_d_r;
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         live_seen_r <= 1'b0;
         live_d_r    <= 1'b0;
      end else begin
         live_d_r <= live_s;
         if (pstate != SIL_PS_S0)
            live_seen_r <= 1'b0;
         else if (live_s)
            live_seen_r <= 1'b1;
      end
   end

   // Fault code select, lowest code first
   logic [7:0] code_nxt;
   always_comb begin
      code_nxt = FC_NONE;
      // Codes 1..3 supply, 4..8 start-up, 9 power-OK
      for (int k = N_FAULT_IN - 1; k >= 0; k--) begin
         if (flt_s[k])
            code_nxt = 8'(k + 1);
      end
      // Both sleep lines high is no valid state
      if (pstate == SIL_PS_BAD)
         code_nxt = FC_INVALID;
   end

   // Latched fault held until restart or power-off
   logic [7:0] code_r;
   logic       restart;
   assign restart = (pstate == SIL_PS_S5);
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I)
         code_r <= FC_NONE;
      else if (code_r == FC_NONE && code_nxt != FC_NONE)
         code_r <= code_nxt;
      else if (restart && code_nxt != FC_INVALID && code_nxt == FC_NONE)
         code_r <= FC_NONE;
   end

   logic fault_act;
   assign fault_act = (code_r != FC_NONE);
   logic flash_lamp;
   sil_flasher #(
      .ON_CYC  (ON_CYC),
      .OFF_CYC (OFF_CYC),
      .PAUSE_C (PAUSE_C)
   ) u_flash (
      .clk_i   (REF_CLK_I),
      .rst_n_i (RSTN_I),
      .en_i    (fault_act),
      .code_i  (code_r),
      .lamp_o  (flash_lamp)
   );

   // Suspend blink, 4 s period keeps it below 0.5 Hz
   logic [31:0] susp_cnt_r;
   logic        susp_ph_r;
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I || pstate != SIL_PS_S3) begin
         susp_cnt_r <= '0;
         susp_ph_r  <= 1'b0;
      end else if (susp_cnt_r >= 32'(SUSP_CYC - 1)) begin
         susp_cnt_r <= '0;
         susp_ph_r  <= ~susp_ph_r;
      end else begin
         susp_cnt_r <= susp_cnt_r + 32'h0000_0001;
      end
   end

   // Status lamp mux
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I)
         SYSTEM_STATUS_LAMP_O <= 1'b0;
      else if (fault_act)
         SYSTEM_STATUS_LAMP_O <= flash_lamp;
      else if (pstate == SIL_PS_S5)
         SYSTEM_STATUS_LAMP_O <= 1'b0;
      else if (pstate == SIL_PS_S3)
         SYSTEM_STATUS_LAMP_O <= susp_ph_r;
      else
         SYSTEM_STATUS_LAMP_O <= live_seen_r;
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I)
         POWER_GOOD_LAMP_O <= 1'b0;
      else
         POWER_GOOD_LAMP_O <= rail_s;
   end

   // Ethernet lamps, a link lamp and an activity lamp per port
   genvar g;
   generate
      for (g = 0; g < N_ETH; g++) begin : g_eth
         always_ff @(posedge REF_CLK_I) begin
            if (!RSTN_I) begin
               ETH_LINK_LAMP_O[g] <= 1'b0;
               ETH_ACT_LAMP_O[g]  <= 1'b0;
            end else begin
               ETH_LINK_LAMP_O[g] <= lnk_s[g];
               ETH_ACT_LAMP_O[g]  <= act_s[g];
            end
         end
      end
   endgenerate

   // Wishbone register access
   logic        wr_acc, rd_acc;
   logic [31:0] ctrl_r;
   logic [N_IRQ-1:0] irq_stat_r, irq_en_r, irq_ev;
   // Write commits at the edge where the master sees ack
   assign wr_acc = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
   assign rd_acc = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I)
         WB_ACK_O <= 1'b0;
      else
         WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
   end

   // Only software writes the user lamps
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I)
         ctrl_r <= CTRL_RST;
      else if (wr_acc && WB_ADR_I == ADR_CTRL && WB_SEL_I[0])
         ctrl_r[7:0] <= WB_DAT_I[7:0];
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         GENERAL_LAMP_FIRST_O  <= 1'b0;
         USB_ACTIVITY_LAMP_O   <= 1'b0;
         GENERAL_LAMP_SECOND_O <= 1'b0;
      end else begin
         GENERAL_LAMP_FIRST_O  <= ctrl_r[CTRL_LAMP_A];
         USB_ACTIVITY_LAMP_O   <= ctrl_r[CTRL_LAMP_USB];
         GENERAL_LAMP_SECOND_O <= ctrl_r[CTRL_LAMP_C];
      end
   end

   // Interrupt events
   logic [7:0] code_d_r;
   sil_pstate_t pstate_d_r;
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         code_d_r   <= FC_NONE;
         pstate_d_r <= SIL_PS_S5;
      end else begin
         code_d_r   <= code_r;
         pstate_d_r <= pstate;
      end
   end
   always_comb begin
      irq_ev            = '0;
      irq_ev[IRQ_FAULT] = fault_act && code_d_r == FC_NONE;
      irq_ev[IRQ_LIVE]  = live_s && !live_d_r;
      irq_ev[IRQ_S0]    = pstate == SIL_PS_S0 && pstate_d_r != SIL_PS_S0;
      irq_ev[IRQ_S3]    = pstate == SIL_PS_S3 && pstate_d_r != SIL_PS_S3;
      irq_ev[IRQ_S5]    = pstate == SIL_PS_S5 && pstate_d_r != SIL_PS_S5;
   end

   // Set wins over a same-cycle clear
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         irq_stat_r <= '0;
         irq_en_r   <= '0;
      end else begin
         if (wr_acc && WB_ADR_I == ADR_IRQ_EN && WB_SEL_I[0])
            irq_en_r <= WB_DAT_I[N_IRQ-1:0];
         if (wr_acc && WB_ADR_I == ADR_IRQ_CLR && WB_SEL_I[0])
            irq_stat_r <= (irq_stat_r & ~WB_DAT_I[N_IRQ-1:0]) | irq_ev;
         else
            irq_stat_r <= irq_stat_r | irq_ev;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I)
         IRQ_O <= 1'b0;
      else
         IRQ_O <= |(irq_stat_r & irq_en_r);
   end

   // Read mux, unmapped and write-only read as zero
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I)
         WB_DAT_O <= '0;
      else if (rd_acc) begin
         case (WB_ADR_I)
            ADR_CTRL:     WB_DAT_O <= ctrl_r;
            ADR_STAT:     WB_DAT_O <= {24'h00_0000, SYSTEM_STATUS_LAMP_O,
                                      POWER_GOOD_LAMP_O, live_seen_r,
                                      fault_act, 2'b00, pstate};
            ADR_IRQ_STAT: WB_DAT_O <= 32'(irq_stat_r);
            ADR_IRQ_EN:   WB_DAT_O <= 32'(irq_en_r);
            ADR_FAULT:    WB_DAT_O <= {24'h00_0000, code_r};
            default:      WB_DAT_O <= '0;
         endcase
      end else
         WB_DAT_O <= '0;
   end
endmodule : sil_lamp_ctrl
`default_nettype wire

// ### verification/sil_lamp_ctrl_properties.sv
// Purpose: Port properties of the lamp controller
// Assumes: One clock, sync active-low reset
// Notes:   Bound to every controller instance
`timescale 1ns/1ps
`default_nettype none
module sil_lamp_ctrl_chk #(
   parameter int N_ETH = 2
) (
   // Clock, reset and bus
   input wire logic             REF_CLK_I,
   input wire logic             RSTN_I,
   input wire logic             WB_WE_I,
   input wire logic             WB_CYC_I,
   input wire logic             WB_STB_I,
   input wire logic [31:0]      WB_DAT_O,
   input wire logic             WB_ACK_O,
   // Host side
   input wire logic             HOST_S3_I,
   input wire logic             HOST_S5_I,
   input wire logic             RAIL_12V_OK_I,
   input wire logic [8:0]       FAULT_I,
   input wire logic [N_ETH-1:0] ETH_LINK_I,
   input wire logic [N_ETH-1:0] ETH_ACT_I,
   // Lamps
   input wire logic             POWER_GOOD_LAMP_O,
   input wire logic             SYSTEM_STATUS_LAMP_O,
   input wire logic             GENERAL_LAMP_FIRST_O,
   input wire logic             USB_ACTIVITY_LAMP_O,
   input wire logic             GENERAL_LAMP_SECOND_O,
   input wire logic [N_ETH-1:0] ETH_LINK_LAMP_O,
   input wire logic [N_ETH-1:0] ETH_ACT_LAMP_O
);
   // Reset history, so $past never looks into a reset
   logic [3:0] rh_r;
   logic [2:0] usr;
   logic       wr;
   assign usr = {GENERAL_LAMP_SECOND_O, USB_ACTIVITY_LAMP_O,
                 GENERAL_LAMP_FIRST_O};
   assign wr = WB_WE_I && WB_ACK_O;
   always_ff @(posedge REF_CLK_I) begin
      rh_r <= {rh_r[2:0], RSTN_I};
   end
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RSTN_I);
   a_s5_lamp_dark: assert property (
      (HOST_S5_I && !HOST_S3_I && FAULT_I == 9'h000)[*8]
      |-> !SYSTEM_STATUS_LAMP_O) else $error("status lamp lit in S5");
   a_pg_tracks_rail: assert property (
      &rh_r[2:0] |-> POWER_GOOD_LAMP_O == $past(RAIL_12V_OK_I, 3))
      else $error("power good lamp wrong");
   a_link_lamp_tracks: assert property (
      &rh_r[2:0] |-> ETH_LINK_LAMP_O == $past(ETH_LINK_I, 3))
      else $error("link lamp wrong");
   a_act_lamp_tracks: assert property (
      &rh_r[2:0] |-> ETH_ACT_LAMP_O == $past(ETH_ACT_I, 3))
      else $error("activity lamp wrong");
   a_ack_one_cycle: assert property (
      WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
   a_ack_after_req: assert property (
      WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack missing");
   a_dat_zero_idle: assert property (
      !WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
      else $error("read data outside ack");
   a_user_lamp_sw: assert property (
      &rh_r[1:0] && $changed(usr) |-> wr || $past(wr) || $past(wr, 2))
      else $error("user lamp moved without write");
   a_user_lamp_rst: assert property (
      !rh_r[0] |-> usr == 3'h0) else $error("user lamp lit at reset");
   c_write: cover property (wr);
   c_flash: cover property ($rose(SYSTEM_STATUS_LAMP_O));
   c_pg_on: cover property ($rose(POWER_GOOD_LAMP_O));
endmodule : sil_lamp_ctrl_chk
bind sil_lamp_ctrl sil_lamp_ctrl_chk #(.N_ETH(N_ETH)) u_chk (
   .REF_CLK_I, .RSTN_I, .WB_WE_I, .WB_CYC_I, .WB_STB_I, .WB_DAT_O,
   .WB_ACK_O, .HOST_S3_I, .HOST_S5_I, .RAIL_12V_OK_I, .FAULT_I,
   .ETH_LINK_I, .ETH_ACT_I, .POWER_GOOD_LAMP_O, .SYSTEM_STATUS_LAMP_O,
   .GENERAL_LAMP_FIRST_O, .USB_ACTIVITY_LAMP_O, .GENERAL_LAMP_SECOND_O,
   .ETH_LINK_LAMP_O, .ETH_ACT_LAMP_O);
`default_nettype wire

// ### verification/sil_panel_model.sv
// Purpose: Front panel watcher, measures status lamp runs
// Assumes: Dark run longer than GAP ends a burst
// Notes:   Burst count is final only at the next burst
`timescale 1ns/1ps
`default_nettype none
module sil_panel_model #(
   parameter int GAP = 12
) (
   // Clock and lamp
   input  wire logic clk_i,
   input  wire logic lamp_i,
   // Measurements
   output logic [7:0] burst_o,
   output int         hi_len_o,
   output int         lo_len_o
);
   logic [7:0] cnt_r  = 8'h00;
   logic       prev_r = 1'b0;
   int         run_r  = 0;
   always @(posedge clk_i) begin
      prev_r <= lamp_i;
      run_r  <= (lamp_i == prev_r) ? run_r + 1 : 1;
      if (lamp_i && !prev_r) begin
         lo_len_o <= run_r;
         cnt_r    <= (run_r > GAP) ? 8'h01 : cnt_r + 8'h01;
         if (run_r > GAP) burst_o <= cnt_r;
      end
      if (!lamp_i && prev_r) hi_len_o <= run_r;
   end
endmodule : sil_panel_model
`default_nettype wire

// ### verification/sil_lamp_ctrl_test.sv
// Purpose: Self-checking bench for the lamp controller
// Assumes: Short counts for flash, pause and blink
// Notes:   Bus tasks wait for ack, watchdog ends hangs
`timescale 1ns/1ps
`default_nettype none
module sil_lamp_ctrl_test
   import sil_pkg::*;
;
   // Short counts keep the run small
   localparam int PSE = 20;
   localparam int FL  = 5;
   localparam int SUS = 16;
   logic        clk, rst_n, cyc, stb, we, ack, s3, s5, live, rail;
   logic        pg, st, irq;
   logic [7:0]  adr, burst;
   logic [3:0]  sel;
   logic [31:0] dw, dr, q;
   logic [8:0]  flt;
   logic [2:0]  usr;
   logic [1:0]  lnk, act, ll, al;
   int          hi_len, lo_len, e;
   int          n_errors = 0;
   int          check_count = 0;
   sil_lamp_ctrl #(.PAUSE_C(PSE), .ON_CYC(FL), .OFF_CYC(FL),
                   .SUSP_CYC(SUS)) dut (
      .REF_CLK_I(clk), .RSTN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw),
      .WB_DAT_O(dr), .WB_ACK_O(ack), .HOST_S3_I(s3), .HOST_S5_I(s5),
      .LIVE_SIGN_I(live), .RAIL_12V_OK_I(rail), .FAULT_I(flt),
      .ETH_LINK_I(lnk), .ETH_ACT_I(act), .POWER_GOOD_LAMP_O(pg),
      .SYSTEM_STATUS_LAMP_O(st), .GENERAL_LAMP_FIRST_O(usr[0]),
      .USB_ACTIVITY_LAMP_O(usr[1]), .GENERAL_LAMP_SECOND_O(usr[2]),
      .ETH_LINK_LAMP_O(ll), .ETH_ACT_LAMP_O(al), .IRQ_O(irq));
   sil_panel_model #(.GAP(12)) u_panel (.clk_i(clk), .lamp_i(st),
      .burst_o(burst), .hi_len_o(hi_len), .lo_len_o(lo_len));
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // Holds the request until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dw  <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      r = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic check(input string nm, input logic [31:0] x,
                        input logic [31:0] g);
      check_count++;
      if (g !== x) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, x, g);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      tick(20000);
      n_errors++;
      summarize();
   end
   initial begin
      {rst_n, cyc, stb, we, adr, dw, flt, lnk, act} = '0;
      {s3, s5, live, rail} = 4'b0100;
      sel = 4'hF;
      tick(6);
      rst_n <= 1'b1;
      wb(0, ADR_CTRL, 0, q);
      check("ctrl", 0, q);
      check("user lamps", 0, usr);
      wb(0, 8'h20, 0, q);
      check("unmapped", 0, q);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         wb(1, ADR_CTRL, i, q);
         tick(2);
         check("user lamps", i, usr);
      end
      $display("test user lamps done");
      for (int i = 0; i < 2; i++) begin
         rail <= i[0];
         lnk  <= {i[0], ~i[0]};
         act  <= {~i[0], i[0]};
         tick(4);
         check("power good", i[0], pg);
         check("link lamps", lnk, ll);
         check("act lamps", act, al);
      end
      $display("test follow lamps done");
      check("s5 lamp", 0, st);
      wb(1, ADR_IRQ_EN, 32'h0000_001F, q);
      s5 <= 1'b0;
      tick(10);
      check("no live sign", 0, st);
      wb(0, ADR_IRQ_STAT, 0, q);
      check("irq s0", 32'h0000_0004, q);
      check("irq line", 1, irq);
      wb(1, ADR_IRQ_CLR, 32'h0000_001F, q);
      tick(3);
      check("irq cleared", 0, irq);
      live <= 1'b1;
      tick(8);
      check("live lamp", 1, st);
      wb(0, ADR_STAT, 0, q);
      check("status reg", 32'h0000_00E0, q);
      wb(1, ADR_IRQ_EN, 0, q);
      tick(3);
      check("irq masked", 0, irq);
      wb(0, ADR_IRQ_STAT, 0, q);
      check("irq live", 32'h0000_0002, q);
      s3 <= 1'b1;
      live <= 1'b0;
      tick(80);
      check("blink high", SUS, hi_len);
      check("blink low", SUS, lo_len);
      s3 <= 1'b0;
      tick(10);
      check("live forgotten", 0, st);
      wb(0, ADR_IRQ_STAT, 0, q);
      check("irq s3 s0", 32'h0000_000E, q);
      $display("test power states done");
      for (int k = 1; k <= 10; k++) begin
         e = (k < 10) ? k : 255;
         flt <= (k < 10) ? 9'(1 << (k - 1)) : 9'h000;
         {s3, s5} <= {2{k == 10}};
         tick(2 * (10 * e + PSE + 10));
         wb(0, ADR_FAULT, 0, q);
         check("fault code", e, q);
         check("flash count", e, burst);
         flt <= '0;
         {s3, s5} <= 2'b01;
         tick(12);
         check("s5 after fault", 0, st);
      end
      wb(0, ADR_IRQ_STAT, 0, q);
      check("irq fault s5", 32'h0000_001F, q);
      wb(1, ADR_IRQ_CLR, 32'h0000_001F, q);
      wb(0, ADR_IRQ_STAT, 0, q);
      check("irq all clear", 0, q);
      $display("test faults done");
      summarize();
   end
endmodule : sil_lamp_ctrl_test
`default_nettype wire
